//--- hdl/bfs_pkg.sv
// Package with register map, field positions, reset values and carriers for the status bank
package bfs_pkg;

  // Serial frame layout: write flag, address field, data word
  localparam int FRAME_BITS = 40;
  localparam int ADDR_W = 7;
  localparam int DATA_W = 32;
  localparam int CNT_W = 6;
  localparam logic [CNT_W-1:0] CNT_LAST = 6'h27;
  localparam logic [CNT_W-1:0] CNT_DONE = 6'h28;
  localparam logic [CNT_W-1:0] CNT_ZERO = 6'h00;

  // Register addresses in the frame address field
  localparam logic [ADDR_W-1:0] ADDR_FIRST = 7'h01;
  localparam logic [ADDR_W-1:0] ADDR_SECOND = 7'h02;
  localparam logic [ADDR_W-1:0] ADDR_THIRD = 7'h03;

  // First status register fields
  localparam int BIT_ADDR_ERR = 13;
  localparam int BIT_CLK_LOSS = 12;
  localparam int BIT_BAT_UV = 11;
  localparam int BIT_LOGIC_UV = 10;
  localparam int BIT_ONE_SUM = 9;
  localparam int BIT_TWO_SUM = 8;

  // Second status register fields
  localparam int BIT_OC_THR = 27;
  localparam int BIT_OC_START = 26;
  localparam int BIT_OLRUN_THR = 23;
  localparam int BIT_OLRUN_START = 22;
  localparam int BIT_OLIDLE_THR = 21;
  localparam int BIT_OLIDLE_START = 20;
  localparam int FAULT_HI = 19;
  localparam int FAULT_LO = 15;

  // Reset values
  localparam logic [5:0] DIAG_RST = 6'h3f;
  localparam logic FLAG_RST = 1'b0;
  localparam logic [DATA_W-1:0] WORD_ZERO = 32'h0000_0000;
  localparam logic [FRAME_BITS-1:0] FRAME_ZERO = 40'h00_0000_0000;

  // Timing: reference period and external clock loss timeout
  localparam int REF_PERIOD_NS = 100;
  localparam int CLK_LOSS_NS = 100000;
  localparam int CLK_LOSS_CYC = (CLK_LOSS_NS + REF_PERIOD_NS - 1) / REF_PERIOD_NS;
  localparam int LOSS_W = 10;
  localparam logic [LOSS_W-1:0] LOSS_LIMIT = LOSS_W'(CLK_LOSS_CYC - 1);

  // Per channel operating faults, msb first: hs first, hs second, ls first, ls second, open run
  typedef struct packed {
    logic hs_oc_first;
    logic hs_oc_second;
    logic ls_oc_first;
    logic ls_oc_second;
    logic open_run;
  } bfs_fault_t;

  // Analog side levels; diag holds self diagnosis results: oc thr, oc start, olrun thr, olrun start, olidle thr, olidle start
  typedef struct packed {
    logic bat_uv;
    logic logic_uv;
    bfs_fault_t channel_one;
    bfs_fault_t channel_two;
    logic diag_done;
    logic [5:0] diag;
  } bfs_sense_t;

  // Received frame
  typedef struct packed {
    logic wr;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } bfs_frame_t;

  // Core command sequencer
  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_EXEC = 2'b10
  } bfs_state_t;

endpackage : bfs_pkg

//--- hdl/bfs_sync.sv
// Two-flop level synchroniser, one per bit
`timescale 1ns/1ns
module bfs_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Data
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  logic [W-1:0] meta;

  // First stage feeds only the second stage
  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_bit
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          meta[i] <= 1'b0;
          q[i] <= 1'b0;
        end else begin
          meta[i] <= d[i];
          q[i] <= meta[i];
        end
      end
    end
  endgenerate

endmodule : bfs_sync

//--- hdl/bfs_status.sv
// Fault and diagnosis status bank with serial register link
//
// Overview of operation
// - Bad address sets bit 13, host clears
// - Stalled external clock sets bit 12
// - Bit 11 follows battery undervoltage, read-only
// - Logic undervoltage latches bit 10 until cleared
// - Bit 9 ORs second status bits 19..15
// - Bit 8 ORs third status bits 19..15
// - Second status at address 0x02, read-only
// - Bit 27 overcurrent threshold diagnosis, resets 1
// - Bit 26 overcurrent diagnosis start fault, resets 1
// - Bit 23 running open-load threshold, resets 1
// - Bit 22 running open-load start fault
// - Bit 21 idle open-load threshold, resets 1
// - Bit 20 idle open-load start fault
// - Bit 19 high-side overcurrent first output
// - Bit 18 high-side overcurrent second output
// - Bits 17,16 low-side overcurrent both outputs
// - Bit 15 channel one running open load
`timescale 1ns/1ns
module bfs_status
  import bfs_pkg::*;
(
  // Core clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // Serial link, clocked by the host
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic mosi,
  output logic miso,
  // Detector and diagnosis levels from the analog side
  input wire bfs_sense_t sense,
  input wire logic pwm_clk
);

  ////////////////////////////////////////////////////////////////////////////
  // Link domain (sclk)

  logic frame_rst_n;
  logic [CNT_W-1:0] bit_cnt;
  logic [CNT_W-1:0] next_bit_cnt;
  logic [FRAME_BITS-1:0] rx_shift;
  logic [FRAME_BITS-1:0] next_rx_shift;
  logic [FRAME_BITS-1:0] tx_shift;
  logic [FRAME_BITS-1:0] next_tx_shift;
  logic next_miso;
  bfs_frame_t frame_q;
  bfs_frame_t next_frame_q;
  logic frame_tgl;
  logic next_frame_tgl;
  logic [FRAME_BITS-1:0] resp_q;

  // Deselect ends the frame; the link clock may stop right after
  assign frame_rst_n = rst_n & ~cs_n;

  // Shift in on rising edge, present reply bit on the same edge
  always_comb begin
    next_bit_cnt = bit_cnt;
    next_rx_shift = rx_shift;
    next_tx_shift = {tx_shift[FRAME_BITS-2:0], 1'b0};
    next_miso = tx_shift[FRAME_BITS-1];
    next_frame_q = frame_q;
    next_frame_tgl = frame_tgl;
    if (bit_cnt == CNT_ZERO) begin
      // Reply word is held still by the core between frames
      next_tx_shift = {resp_q[FRAME_BITS-2:0], 1'b0};
      next_miso = resp_q[FRAME_BITS-1];
    end
    if (bit_cnt != CNT_DONE) begin
      next_bit_cnt = bit_cnt + 6'h01;
      next_rx_shift = {rx_shift[FRAME_BITS-2:0], mosi};
    end
    if (bit_cnt == CNT_LAST) begin
      // Excess bits after the last are ignored
      next_frame_q = bfs_frame_t'({rx_shift[FRAME_BITS-2:0], mosi});
      next_frame_tgl = ~frame_tgl;
    end
  end

  // Per-frame state, cleared by deselect
  always_ff @(posedge sclk or negedge frame_rst_n) begin
    if (!frame_rst_n) begin
      bit_cnt <= CNT_ZERO;
      rx_shift <= FRAME_ZERO;
      tx_shift <= FRAME_ZERO;
      miso <= 1'b0;
    end else begin
      bit_cnt <= next_bit_cnt;
      rx_shift <= next_rx_shift;
      tx_shift <= next_tx_shift;
      miso <= next_miso;
    end
  end

  // Completed frame and its event toggle survive deselect
  always_ff @(posedge sclk or negedge rst_n) begin
    if (!rst_n) begin
      frame_q <= bfs_frame_t'(FRAME_ZERO);
      frame_tgl <= 1'b0;
    end else begin
      frame_q <= next_frame_q;
      frame_tgl <= next_frame_tgl;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Crossings into the core domain

  logic tgl_s;
  logic tgl_d;
  logic new_frame;
  logic pwm_s;
  logic pwm_d;
  bfs_sense_t sense_s;

  // Frame event travels as a toggle
  bfs_sync #(.W(1)) u_sync_tgl (
    .clk(ref_clk),
    .rst_n(rst_n),
    .d(frame_tgl),
    .q(tgl_s)
  );

  // External pulse-width clock, sampled as a level
  bfs_sync #(.W(1)) u_sync_pwm (
    .clk(ref_clk),
    .rst_n(rst_n),
    .d(pwm_clk),
    .q(pwm_s)
  );

  // Detector levels from outside the clock domain
  bfs_sync #(.W($bits(bfs_sense_t))) u_sync_sense (
    .clk(ref_clk),
    .rst_n(rst_n),
    .d(sense),
    .q(sense_s)
  );

  // Edge history for the toggle and the external clock
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      tgl_d <= 1'b0;
      pwm_d <= 1'b0;
    end else begin
      tgl_d <= tgl_s;
      pwm_d <= pwm_s;
    end
  end

  assign new_frame = tgl_s ^ tgl_d;

  ////////////////////////////////////////////////////////////////////////////
  // External clock supervision

  logic [LOSS_W-1:0] loss_cnt;
  logic [LOSS_W-1:0] next_loss_cnt;
  logic loss_hit;

  // Count cycles since the last edge; saturate at the limit
  always_comb begin
    next_loss_cnt = loss_cnt;
    loss_hit = 1'b0;
    if (pwm_s ^ pwm_d) begin
      next_loss_cnt = '0;
    end else if (loss_cnt == LOSS_LIMIT) begin
      loss_hit = 1'b1;
    end else begin
      next_loss_cnt = loss_cnt + 10'h001;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      loss_cnt <= '0;
    end else begin
      loss_cnt <= next_loss_cnt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Command sequencer and register bank

  bfs_state_t state;
  bfs_state_t next_state;
  bfs_frame_t cmd;
  bfs_frame_t next_cmd;
  logic [FRAME_BITS-1:0] next_resp_q;
  logic addr_err;
  logic next_addr_err;
  logic clk_loss;
  logic next_clk_loss;
  logic logic_uv;
  logic next_logic_uv;
  logic [5:0] diag_q;
  logic [5:0] next_diag_q;
  logic [DATA_W-1:0] first_word;
  logic [DATA_W-1:0] second_word;
  logic [DATA_W-1:0] third_word;
  logic [DATA_W-1:0] rd_word;
  logic addr_ok;
  logic clr_addr;
  logic clr_loss;
  logic clr_uv;

  // Register images; unlisted bits read as zero
  always_comb begin
    first_word = WORD_ZERO;
    first_word[BIT_ADDR_ERR] = addr_err;
    first_word[BIT_CLK_LOSS] = clk_loss;
    first_word[BIT_BAT_UV] = sense_s.bat_uv;
    first_word[BIT_LOGIC_UV] = logic_uv;
    first_word[BIT_ONE_SUM] = |sense_s.channel_one;
    first_word[BIT_TWO_SUM] = |sense_s.channel_two;
    second_word = WORD_ZERO;
    second_word[BIT_OC_THR] = diag_q[5];
    second_word[BIT_OC_START] = diag_q[4];
    second_word[BIT_OLRUN_THR] = diag_q[3];
    second_word[BIT_OLRUN_START] = diag_q[2];
    second_word[BIT_OLIDLE_THR] = diag_q[1];
    second_word[BIT_OLIDLE_START] = diag_q[0];
    // Live detector levels: hs1, hs2, ls1, ls2, open run
    second_word[FAULT_HI:FAULT_LO] = sense_s.channel_one;
    third_word = WORD_ZERO;
    third_word[FAULT_HI:FAULT_LO] = sense_s.channel_two;
  end

  // Address decode and read mux
  always_comb begin
    addr_ok = 1'b1;
    rd_word = WORD_ZERO;
    case (cmd.addr)
      ADDR_FIRST: rd_word = first_word;
      ADDR_SECOND: rd_word = second_word;
      ADDR_THIRD: rd_word = third_word;
      default: addr_ok = 1'b0;
    endcase
  end

  // Clear strobes only from a write of one to the first register
  always_comb begin
    clr_addr = 1'b0;
    clr_loss = 1'b0;
    clr_uv = 1'b0;
    if (state == ST_EXEC && cmd.wr && cmd.addr == ADDR_FIRST) begin
      clr_addr = cmd.data[BIT_ADDR_ERR];
      clr_loss = cmd.data[BIT_CLK_LOSS];
      clr_uv = cmd.data[BIT_LOGIC_UV];
    end
  end

  // Sequencer: take a frame, execute it, prepare the next reply
  always_comb begin
    next_state = state;
    next_cmd = cmd;
    next_resp_q = resp_q;
    case (state)
      ST_IDLE: begin
        if (new_frame) begin
          // Frame word is stable until the next frame completes
          next_cmd = frame_q;
          next_state = ST_EXEC;
        end
      end
      ST_EXEC: begin
        // Reply carries the pre-write image; writes to read-only words drop
        next_resp_q = {1'b0, cmd.addr, rd_word};
        next_state = ST_IDLE;
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  // Sticky flags: a set in the clearing cycle wins
  always_comb begin
    next_addr_err = (addr_err & ~clr_addr) | (state == ST_EXEC && !addr_ok);
    next_clk_loss = (clk_loss & ~clr_loss) | loss_hit;
    next_logic_uv = (logic_uv & ~clr_uv) | sense_s.logic_uv;
    // Diagnosis results load while the diagnosis reports done, else hold
    next_diag_q = sense_s.diag_done ? sense_s.diag : diag_q;
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= ST_IDLE;
      cmd <= bfs_frame_t'(FRAME_ZERO);
      resp_q <= FRAME_ZERO;
      addr_err <= FLAG_RST;
      clk_loss <= FLAG_RST;
      logic_uv <= FLAG_RST;
      diag_q <= DIAG_RST;
    end else begin
      state <= next_state;
      cmd <= next_cmd;
      resp_q <= next_resp_q;
      addr_err <= next_addr_err;
      clk_loss <= next_clk_loss;
      logic_uv <= next_logic_uv;
      diag_q <= next_diag_q;
    end
  end

endmodule : bfs_status

//--- verif/bfs_status_props.sv
// Port-level checker for the status bank reply stream
`timescale 1ns/1ns
module bfs_status_props
  import bfs_pkg::*;
(
  // Clocks and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // Serial link
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic mosi,
  input wire logic miso,
  // Analog side
  input wire bfs_sense_t sense,
  input wire logic pwm_clk
);
  logic [5:0] bcnt;
  logic [5:0] next_bcnt;
  logic [37:0] sr;
  logic [37:0] next_sr;
  logic [6:0] pa;
  logic [6:0] next_pa;
  logic [5:0] ri;
  // Reply bit index at the falling edge; the last bit is skipped as pa moves on then
  assign ri = 6'h28 - bcnt;
  // Edge count per frame and address of the last whole frame
  always_comb begin
    next_bcnt = (bcnt == CNT_DONE) ? bcnt : bcnt + 6'h01;
    next_sr = {sr[36:0], mosi};
    next_pa = (bcnt == CNT_LAST) ? sr[37:31] : pa;
  end
  always_ff @(posedge sclk or posedge cs_n) begin
    if (cs_n) bcnt <= CNT_ZERO;
    else bcnt <= next_bcnt;
  end
  always_ff @(posedge sclk or negedge rst_n) begin
    if (!rst_n) begin
      sr <= '0;
      pa <= 7'h00;
    end else begin
      sr <= next_sr;
      pa <= next_pa;
    end
  end
  ////////////////////////////////////////////////////////////
  // Reply line checks: bits that must read zero, address echo, level after reset, hold while deselected
  property p_quiet(logic c);
    @(negedge sclk) disable iff (!rst_n) (bcnt inside {[1:39]}) && c |-> !miso;
  endproperty
  a_lead_zero: assert property (p_quiet(ri == 6'h27))
    else $error("reply lead bit not zero");
  a_bad_zero: assert property (p_quiet(!(pa inside {[1:3]}) && ri < 6'h20))
    else $error("unmapped reply data not zero");
  a_second_unused: assert property (p_quiet(pa == ADDR_SECOND &&
    (ri inside {[28:31], 25, 24} || ri < 6'h0f)))
    else $error("second status unused bit set");
  a_third_unused: assert property (p_quiet(pa == ADDR_THIRD &&
    (ri inside {[20:31]} || ri < 6'h0f)))
    else $error("third status unused bit set");
  a_first_unused: assert property (p_quiet(pa == ADDR_FIRST &&
    (ri inside {[14:31]} || ri < 6'h08)))
    else $error("first status unused bit set");
  a_addr_echo: assert property (@(negedge sclk) disable iff (!rst_n)
    (bcnt != 6'h00) && (ri inside {[32:38]}) |-> miso == pa[ri - 6'h20])
    else $error("reply address not echoed");
  a_reset_quiet: assert property (@(posedge ref_clk) disable iff (!rst_n)
    $rose(rst_n) |-> !miso ##1 !miso)
    else $error("reply line not low after reset");
  a_idle_hold: assert property (@(posedge ref_clk) disable iff (!rst_n)
    cs_n && $past(cs_n) |-> $stable(miso))
    else $error("reply line moved while deselected");
  // Main scenarios
  c_second: cover property (@(negedge sclk) pa == ADDR_SECOND && miso);
  c_bad: cover property (@(negedge sclk) pa == 7'h7f && bcnt == 6'h14);
  c_loss: cover property (@(negedge sclk) pa == ADDR_FIRST && ri == 6'h0c && miso);
endmodule : bfs_status_props

bind bfs_status bfs_status_props i_bfs_status_props (.ref_clk(ref_clk), .rst_n(rst_n),
  .sclk(sclk), .cs_n(cs_n), .mosi(mosi), .miso(miso), .sense(sense), .pwm_clk(pwm_clk));

//--- verif/bfs_host.sv
// Host side of the serial link: 40-bit frames, msb first, 30 ns bit clock
`timescale 1ns/1ns
module bfs_host (
  // Link pins driven by the host
  output logic sclk,
  output logic cs_n,
  output logic mosi,
  // Device reply
  input wire logic miso
);
  // Idle link: clock parked low, device deselected
  initial begin
    sclk = 1'b0;
    cs_n = 1'b0;
    mosi = 1'b0;
    // Deselect just after time zero, so frame logic sees a real reset edge
    #1 cs_n = 1'b1;
  end
  // One frame; its reply carries the answer to the previous frame
  task automatic xfer(input logic [39:0] f, output logic [39:0] r);
    int k;
    #7 cs_n = 1'b0;
    for (k = 39; k >= 0; k--) begin
      mosi = f[k];
      #15 sclk = 1'b1;
      #15 sclk = 1'b0;
      r[k] = miso;
    end
    #15 cs_n = 1'b1;
    // Line no longer meaningful, so show the opposite level
    mosi = ~mosi;
    // Spacing well above the core execute time
    #1000;
  endtask : xfer
endmodule : bfs_host

//--- verif/tb.sv
// Self-checking bench for the status bank
`timescale 1ns/1ns
module tb
  import bfs_pkg::*;
;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b1;
  logic pwm_clk = 1'b0;
  logic pwm_run = 1'b1;
  logic sclk;
  logic cs_n;
  logic mosi;
  logic miso;
  bfs_sense_t sn = '0;
  bfs_sense_t v;
  logic [39:0] rp;
  int mismatches = 0;
  int samples_checked = 0;
  int i;
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin mismatches++; \
  $display("BAD %0t got %h exp %h", $time, (g), (e)); end end

  // Core clock and a supervised clock that can be stalled
  always #50 ref_clk = ~ref_clk;
  always @(negedge ref_clk) if (pwm_run) pwm_clk <= ~pwm_clk;

  bfs_status i_bfs_status (.ref_clk(ref_clk), .rst_n(rst_n), .sclk(sclk), .cs_n(cs_n),
    .mosi(mosi), .miso(miso), .sense(sn), .pwm_clk(pwm_clk));
  bfs_host i_bfs_host (.sclk(sclk), .cs_n(cs_n), .mosi(mosi), .miso(miso));
  ////////////////////////////////////////////////////////////
  task automatic close_out();
    $display("mismatches %0d samples_checked %0d", mismatches, samples_checked);
    if (mismatches == 0 && samples_checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : close_out
  task automatic wr(input logic [6:0] a, input logic [31:0] d);
    i_bfs_host.xfer({1'b1, a, d}, rp);
  endtask : wr
  // Read needs a second frame to carry the answer back
  task automatic rd(input logic [6:0] a, input logic [31:0] e);
    i_bfs_host.xfer({1'b0, a, WORD_ZERO}, rp);
    i_bfs_host.xfer({1'b0, ADDR_FIRST, WORD_ZERO}, rp);
    `CHK(rp[38:32], a)
    `CHK(rp[31:0], e)
  endtask : rd
  // Sense levels need a few core cycles to pass the synchroniser
  task automatic put(input bfs_sense_t s);
    @(negedge ref_clk);
    sn = s;
    repeat (4) @(negedge ref_clk);
  endtask : put
  function automatic logic [31:0] dw(input logic [5:0] d);
    return {4'h0, d[5:4], 2'h0, d[3:0], 20'h0_0000};
  endfunction : dw
  ////////////////////////////////////////////////////////////
  initial begin
    // Assert after time zero so every flop sees the falling reset edge
    #1 rst_n = 1'b0;
    repeat (12) @(negedge ref_clk);
    rst_n = 1'b1;
    repeat (4) @(negedge ref_clk);
    rd(ADDR_SECOND, dw(DIAG_RST));
    rd(ADDR_THIRD, WORD_ZERO);
    rd(ADDR_FIRST, WORD_ZERO);
    // Diagnosis loads while done is high, then holds
    for (i = 0; i < 2; i++) begin
      v = '0;
      v.diag_done = 1'b1;
      v.diag = i ? 6'h15 : 6'h2a;
      put(v);
      v.diag_done = 1'b0;
      v.diag = ~v.diag;
      put(v);
      rd(ADDR_SECOND, dw(i ? 6'h15 : 6'h2a));
    end
    // Live faults one bit at a time on both channels
    for (i = 0; i < 5; i++) begin
      v = '0;
      v.channel_one = bfs_fault_t'(5'h10 >> i);
      v.channel_two = bfs_fault_t'(5'h10 >> i);
      put(v);
      rd(ADDR_SECOND, dw(6'h15) | (32'h0008_0000 >> i));
      rd(ADDR_THIRD, 32'h0008_0000 >> i);
      rd(ADDR_FIRST, 32'h0000_0300);
    end
    v = '0;
    v.channel_one = bfs_fault_t'(5'h01);
    put(v);
    rd(ADDR_FIRST, 32'h0000_0200);
    // Battery undervoltage follows the level and ignores writes
    v = '0;
    v.bat_uv = 1'b1;
    put(v);
    wr(ADDR_FIRST, 32'h0000_0800);
    rd(ADDR_FIRST, 32'h0000_0800);
    v.bat_uv = 1'b0;
    put(v);
    rd(ADDR_FIRST, WORD_ZERO);
    // Logic undervoltage latches; a zero write keeps it
    v.logic_uv = 1'b1;
    put(v);
    v.logic_uv = 1'b0;
    put(v);
    wr(ADDR_FIRST, WORD_ZERO);
    rd(ADDR_FIRST, 32'h0000_0400);
    wr(ADDR_FIRST, 32'h0000_0400);
    rd(ADDR_FIRST, WORD_ZERO);
    // Unmapped addresses answer zero and latch the error
    rd(7'h04, WORD_ZERO);
    rd(7'h7f, WORD_ZERO);
    rd(ADDR_FIRST, 32'h0000_2000);
    wr(ADDR_FIRST, 32'h0000_2000);
    rd(ADDR_FIRST, WORD_ZERO);
    // Status registers refuse writes
    wr(ADDR_SECOND, 32'hffff_ffff);
    rd(ADDR_SECOND, dw(6'h15));
    wr(ADDR_THIRD, 32'hffff_ffff);
    rd(ADDR_THIRD, WORD_ZERO);
    // Supervised clock stall: quiet before the limit, flagged after
    pwm_run = 1'b0;
    repeat (900) @(negedge ref_clk);
    rd(ADDR_FIRST, WORD_ZERO);
    repeat (200) @(negedge ref_clk);
    rd(ADDR_FIRST, 32'h0000_1000);
    pwm_run = 1'b1;
    wr(ADDR_FIRST, 32'h0000_1000);
    rd(ADDR_FIRST, WORD_ZERO);
    close_out();
  end
  // Hang guard
  initial begin
    repeat (100000) @(posedge ref_clk);
    mismatches++;
    close_out();
  end
endmodule : tb
